/* File: design/trig_mon_pkg.sv */
// Constants shared by the package trigger monitor
`default_nettype none
package trig_mon_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_LC_CFG     = 8'h04;
	localparam logic [7:0] ADDR_MIN_TIME   = 8'h08;
	localparam logic [7:0] ADDR_DEBOUNCE   = 8'h0C;
	localparam logic [7:0] ADDR_GLITCH_THR = 8'h10;
	localparam logic [7:0] ADDR_MAX_LEN    = 8'h14;
	localparam logic [7:0] ADDR_PPI        = 8'h18;
	localparam logic [7:0] ADDR_STATUS     = 8'h20;
	localparam logic [7:0] ADDR_HEIGHT     = 8'h24;
	localparam logic [7:0] ADDR_LC_GLITCH  = 8'h28;
	localparam logic [7:0] ADDR_TIMEOUT    = 8'h2C;
	localparam logic [7:0] ADDR_PE_GLITCH  = 8'h30;
	localparam logic [7:0] ADDR_TACH_TOTAL = 8'h34;
	localparam logic [7:0] ADDR_SPEED      = 8'h38;
	localparam logic [7:0] ADDR_SPEED_MIN  = 8'h3C;
	localparam logic [7:0] ADDR_SPEED_MAX  = 8'h40;
	localparam logic [7:0] ADDR_DEVIATION  = 8'h44;
	localparam logic [7:0] ADDR_TOO_LONG   = 8'h48;
	localparam logic [7:0] ADDR_TOO_SHORT  = 8'h4C;
	localparam logic [7:0] ADDR_TOO_CLOSE  = 8'h50;
	// Control register fields
	localparam int CTRL_MODE_BIT    = 0;
	localparam int CTRL_ACT_LOW_BIT = 1;
	localparam int CTRL_RST_CNT_BIT = 8;
	// Reset values
	localparam logic        RST_MODE     = 1'b0;
	localparam logic        RST_ACT_LOW  = 1'b0;
	localparam logic [7:0]  RST_RES      = 8'h01;
	localparam logic [15:0] RST_OFFSET   = 16'h0000;
	localparam logic [23:0] RST_MIN_TIME = 24'h00_0010;
	localparam logic [23:0] RST_DEBOUNCE = 24'h00_0010;
	localparam logic [15:0] RST_GLT_THR  = 16'h0010;
	localparam logic [23:0] RST_MAX_LEN  = 24'h00_1000;
	localparam logic [15:0] RST_PPI      = 16'h0010;
	// Timing
	localparam int CLK_HZ        = 125_000_000;
	localparam int TIMEOUT_MS    = 100;
	localparam int TIMEOUT_CYC   = (CLK_HZ / 1000) * TIMEOUT_MS;
	localparam int SPEED_SEC     = 1;
	localparam int SPEED_CYC     = CLK_HZ * SPEED_SEC;
	localparam int WINDOW_S      = 30;
	// Package length limits in tenths of an inch
	localparam int TENTHS_PER_IN = 10;
	localparam int SHORT_TENTHS  = 40;
	localparam int CLOSE_TENTHS  = 20;
endpackage
`default_nettype wire

/* File: design/evt_counter.sv */
// Saturating event counter with synchronous clear
`default_nettype none
module evt_counter #(
	parameter int W = 16
) (
	input  wire logic         core_clk, // System clock
	input  wire logic         rstn,     // Async reset, active low
	input  wire logic         clr,      // Clear to zero, or to one if inc
	input  wire logic         inc,      // Count one event
	output logic [W-1:0]      count     // Current count
);
	logic [W-1:0] count_r;
	wire          at_max = &count_r;

	// An event during clear is kept as the first count
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			count_r <= '0;
		else if (clr)
			count_r <= inc ? W'(1) : '0;
		else if (inc && !at_max)
			count_r <= count_r + W'(1);
	end

	assign count = count_r;
endmodule
`default_nettype wire

/* File: design/package_trigger_monitor.sv */
// Package trigger monitor: light curtain, photoeye and tachometer
//
// The implementer's own choices: the plain strobed port and the address map.
`default_nettype none
module package_trigger_monitor #(
	parameter int CNT_W       = 16,
	parameter int TIMEOUT_CYC = trig_mon_pkg::TIMEOUT_CYC,
	parameter int SPEED_CYC   = trig_mon_pkg::SPEED_CYC
) (
	input  wire logic        core_clk,      // 125 MHz clock
	input  wire logic        rstn,          // Async reset, active low
	input  wire logic [7:0]  addr,          // Register byte address
	input  wire logic [31:0] wdata,         // Write data
	input  wire logic        wr_en,         // Write strobe
	input  wire logic        rd_en,         // Read strobe
	output logic [31:0]      rdata,         // Read data, cycle after rd_en
	input  wire logic        lc_char_valid, // Curtain character strobe
	input  wire logic [7:0]  lc_char,       // Curtain ASCII character
	input  wire logic        pe_in,         // Photoeye input level
	input  wire logic        tach_in,       // Tachometer pulse input
	output logic             pkg_present    // Package present, selected mode
);
	import trig_mon_pkg::*;

	// Configuration registers
	logic        mode_r;
	logic        act_low_r;
	logic        rst_cnt_r;
	logic [7:0]  res_r;
	logic [15:0] off_r;
	logic [23:0] min_time_r;
	logic [23:0] debounce_r;
	logic [15:0] glt_thr_r;
	logic [23:0] max_len_r;
	logic [15:0] ppi_r;
	logic [31:0] rdata_r;
	logic        pkg_present_r;

	wire wr_ctrl = wr_en && (addr == ADDR_CTRL);
	wire wr_cfg  = wr_en && (addr == ADDR_LC_CFG);
	wire wr_min  = wr_en && (addr == ADDR_MIN_TIME);
	wire wr_deb  = wr_en && (addr == ADDR_DEBOUNCE);
	wire wr_thr  = wr_en && (addr == ADDR_GLITCH_THR);
	wire wr_len  = wr_en && (addr == ADDR_MAX_LEN);
	wire wr_ppi  = wr_en && (addr == ADDR_PPI);
	wire lc_on   = mode_r;
	wire pe_on   = !mode_r;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mode_r     <= RST_MODE;
			act_low_r  <= RST_ACT_LOW;
			rst_cnt_r  <= 1'b0;
			res_r      <= RST_RES;
			off_r      <= RST_OFFSET;
			min_time_r <= RST_MIN_TIME;
			debounce_r <= RST_DEBOUNCE;
			glt_thr_r  <= RST_GLT_THR;
			max_len_r  <= RST_MAX_LEN;
			ppi_r      <= RST_PPI;
		end
		else
		begin
			rst_cnt_r <= wr_ctrl && wdata[CTRL_RST_CNT_BIT];
			if (wr_ctrl)
			begin
				mode_r    <= wdata[CTRL_MODE_BIT];
				act_low_r <= wdata[CTRL_ACT_LOW_BIT];
			end
			if (wr_cfg)
			begin
				res_r <= wdata[7:0];
				off_r <= wdata[31:16];
			end
			if (wr_min)
				min_time_r <= wdata[23:0];
			if (wr_deb)
				debounce_r <= wdata[23:0];
			if (wr_thr)
				glt_thr_r <= wdata[15:0];
			if (wr_len)
				max_len_r <= wdata[23:0];
			if (wr_ppi)
				ppi_r <= wdata[15:0];
		end
	end

	// Light curtain
	logic [7:0]  char_r;
	logic [15:0] height_r;
	logic [15:0] h_prev_r;
	logic [1:0]  nsamp_r;
	logic [23:0] lc_run_r;
	logic        lc_present_r;
	logic [31:0] idle_r;
	logic        lc_timeout_r;
	logic        lc_glitch_r;

	wire         lc_take  = lc_char_valid && lc_on;
	wire [15:0]  h_new    = 16'(lc_char) * 16'(res_r) + off_r;
	wire [15:0]  d_first  = (height_r > h_prev_r) ? height_r - h_prev_r
	                                               : h_prev_r - height_r;
	wire [15:0]  d_last   = (height_r > h_new) ? height_r - h_new
	                                           : h_new - height_r;
	wire         glt_seen = lc_take && (nsamp_r == 2'd2) &&
	                        (d_first > glt_thr_r) && (d_last > glt_thr_r);
	wire         lc_act   = lc_on && (height_r != 16'h0000);
	wire         idle_end = (idle_r == 32'(TIMEOUT_CYC - 1));

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			char_r       <= 8'h00;
			height_r     <= 16'h0000;
			h_prev_r     <= 16'h0000;
			nsamp_r      <= 2'd0;
			lc_run_r     <= 24'h00_0000;
			lc_present_r <= 1'b0;
			idle_r       <= 32'h0000_0000;
			lc_timeout_r <= 1'b0;
			lc_glitch_r  <= 1'b0;
		end
		else
		begin
			lc_glitch_r <= glt_seen;
			if (lc_take)
			begin
				char_r   <= lc_char;
				height_r <= h_new;
				h_prev_r <= height_r;
				if (nsamp_r != 2'd2)
					nsamp_r <= nsamp_r + 2'd1;
			end
			if (!lc_act)
				lc_run_r <= 24'h00_0000;
			else if (lc_run_r != 24'hFF_FFFF)
				lc_run_r <= lc_run_r + 24'h00_0001;
			lc_present_r <= lc_act && (lc_run_r >= min_time_r);
			lc_timeout_r <= lc_on && !lc_take && idle_end;
			if (!lc_on || lc_take || idle_end)
				idle_r <= 32'h0000_0000;
			else
				idle_r <= idle_r + 32'h0000_0001;
		end
	end

	// Photoeye
	logic        pe_raw_r;
	logic        pe_stable_r;
	logic [23:0] pe_dev_r;
	logic [23:0] pe_run_r;
	logic        pe_present_r;
	logic        pe_glitch_r;

	wire pe_act    = pe_on && (pe_in ^ act_low_r);
	wire pe_differ = pe_in != pe_stable_r;
	wire pe_settle = pe_differ && ((pe_dev_r + 24'h00_0001) >= debounce_r);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pe_raw_r     <= 1'b0;
			pe_stable_r  <= 1'b0;
			pe_dev_r     <= 24'h00_0000;
			pe_run_r     <= 24'h00_0000;
			pe_present_r <= 1'b0;
			pe_glitch_r  <= 1'b0;
		end
		else
		begin
			pe_raw_r    <= pe_in;
			pe_glitch_r <= pe_on && !pe_differ && (pe_dev_r != 24'h00_0000);
			if (!pe_on || !pe_differ || pe_settle)
				pe_dev_r <= 24'h00_0000;
			else
				pe_dev_r <= pe_dev_r + 24'h00_0001;
			if (!pe_on || pe_settle)
				pe_stable_r <= pe_in;
			if (!pe_act)
				pe_run_r <= 24'h00_0000;
			else if (pe_run_r != 24'hFF_FFFF)
				pe_run_r <= pe_run_r + 24'h00_0001;
			pe_present_r <= pe_act && (pe_run_r >= min_time_r);
		end
	end

	// Tachometer and belt speed
	logic        tach_d_r;
	logic [31:0] tach_total_r;
	logic [31:0] sec_cnt_r;
	logic [15:0] pulses_r;
	logic [15:0] speed_r;
	logic [15:0] speed_min_r;
	logic [15:0] speed_max_r;
	logic        fresh_r;
	logic [23:0] dev_sum_r;
	logic [4:0]  win_cnt_r;
	logic [15:0] dev_r;

	wire        tach_edge = tach_in && !tach_d_r;
	wire        sec_tick  = (sec_cnt_r == 32'(SPEED_CYC - 1));
	wire        win_end   = sec_tick && (win_cnt_r == 5'(WINDOW_S - 1));
	wire [15:0] delta     = (pulses_r > speed_r) ? pulses_r - speed_r
	                                             : speed_r - pulses_r;
	wire [23:0] sum_nxt   = dev_sum_r + 24'(delta);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tach_d_r     <= 1'b0;
			tach_total_r <= 32'h0000_0000;
			sec_cnt_r    <= 32'h0000_0000;
			pulses_r     <= 16'h0000;
			speed_r      <= 16'h0000;
			speed_min_r  <= 16'h0000;
			speed_max_r  <= 16'h0000;
			fresh_r      <= 1'b1;
			dev_sum_r    <= 24'h00_0000;
			win_cnt_r    <= 5'd0;
			dev_r        <= 16'h0000;
		end
		else
		begin
			tach_d_r <= tach_in;
			if (tach_edge)
				tach_total_r <= tach_total_r + 32'h0000_0001;
			sec_cnt_r <= sec_tick ? 32'h0000_0000
			                      : sec_cnt_r + 32'h0000_0001;
			if (sec_tick)
			begin
				pulses_r <= tach_edge ? 16'h0001 : 16'h0000;
				speed_r  <= pulses_r;
				if (fresh_r || pulses_r < speed_min_r)
					speed_min_r <= pulses_r;
				if (fresh_r || pulses_r > speed_max_r)
					speed_max_r <= pulses_r;
			end
			else if (tach_edge && pulses_r != 16'hFFFF)
				pulses_r <= pulses_r + 16'h0001;
			if (rst_cnt_r || win_end)
				fresh_r <= 1'b1;
			else if (sec_tick)
				fresh_r <= 1'b0;
			if (win_end)
			begin
				dev_r     <= 16'(sum_nxt / 24'(WINDOW_S));
				dev_sum_r <= 24'h00_0000;
				win_cnt_r <= 5'd0;
			end
			else if (sec_tick)
			begin
				dev_sum_r <= sum_nxt;
				win_cnt_r <= win_cnt_r + 5'd1;
			end
		end
	end

	// Package length and spacing, measured in tach pulses
	logic        pres_d_r;
	logic        seen_r;
	logic [23:0] len_r;
	logic [23:0] gap_r;
	logic        too_long_r;
	logic        too_short_r;
	logic        too_close_r;

	wire        present  = mode_r ? lc_present_r : pe_present_r;
	wire        pkg_rise = present && !pres_d_r;
	wire        pkg_fall = !present && pres_d_r;
	wire [31:0] len_t    = 32'(len_r) * 32'(TENTHS_PER_IN);
	wire [31:0] gap_t    = 32'(gap_r) * 32'(TENTHS_PER_IN);
	wire [31:0] short_t  = 32'(ppi_r) * 32'(SHORT_TENTHS);
	wire [31:0] close_t  = 32'(ppi_r) * 32'(CLOSE_TENTHS);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pres_d_r      <= 1'b0;
			seen_r        <= 1'b0;
			len_r         <= 24'h00_0000;
			gap_r         <= 24'h00_0000;
			too_long_r    <= 1'b0;
			too_short_r   <= 1'b0;
			too_close_r   <= 1'b0;
			pkg_present_r <= 1'b0;
		end
		else
		begin
			pres_d_r      <= present;
			pkg_present_r <= present;
			too_long_r    <= pkg_fall && (len_r > max_len_r);
			too_short_r   <= pkg_fall && (len_t < short_t);
			too_close_r   <= pkg_rise && seen_r && (gap_t < close_t);
			if (pkg_fall)
				seen_r <= 1'b1;
			if (pkg_rise)
				len_r <= 24'h00_0000;
			else if (present && tach_edge && len_r != 24'hFF_FFFF)
				len_r <= len_r + 24'h00_0001;
			if (pkg_fall)
				gap_r <= 24'h00_0000;
			else if (!present && tach_edge && gap_r != 24'hFF_FFFF)
				gap_r <= gap_r + 24'h00_0001;
		end
	end

	// Error counters
	logic [CNT_W-1:0] cnt_lc_glt;
	logic [CNT_W-1:0] cnt_timeout;
	logic [CNT_W-1:0] cnt_pe_glt;
	logic [CNT_W-1:0] cnt_long;
	logic [CNT_W-1:0] cnt_short;
	logic [CNT_W-1:0] cnt_close;

	evt_counter #(.W(CNT_W)) u_lc_glt (.core_clk(core_clk), .rstn(rstn),
		.clr(rst_cnt_r), .inc(lc_glitch_r), .count(cnt_lc_glt));
	evt_counter #(.W(CNT_W)) u_timeout (.core_clk(core_clk), .rstn(rstn),
		.clr(rst_cnt_r), .inc(lc_timeout_r), .count(cnt_timeout));
	evt_counter #(.W(CNT_W)) u_pe_glt (.core_clk(core_clk), .rstn(rstn),
		.clr(rst_cnt_r), .inc(pe_glitch_r), .count(cnt_pe_glt));
	evt_counter #(.W(CNT_W)) u_long (.core_clk(core_clk), .rstn(rstn),
		.clr(rst_cnt_r), .inc(too_long_r), .count(cnt_long));
	evt_counter #(.W(CNT_W)) u_short (.core_clk(core_clk), .rstn(rstn),
		.clr(rst_cnt_r), .inc(too_short_r), .count(cnt_short));
	evt_counter #(.W(CNT_W)) u_close (.core_clk(core_clk), .rstn(rstn),
		.clr(rst_cnt_r), .inc(too_close_r), .count(cnt_close));

	// Read selection; unmapped addresses read zero
	wire [31:0] status_w = {16'h0000, char_r, 4'h0, pe_present_r,
	                        lc_present_r, pe_raw_r, pkg_present_r};
	wire [31:0] rd_mux =
		(addr == ADDR_CTRL)       ? {30'h0, act_low_r, mode_r} :
		(addr == ADDR_LC_CFG)     ? {off_r, 8'h00, res_r} :
		(addr == ADDR_MIN_TIME)   ? {8'h00, min_time_r} :
		(addr == ADDR_DEBOUNCE)   ? {8'h00, debounce_r} :
		(addr == ADDR_GLITCH_THR) ? {16'h0000, glt_thr_r} :
		(addr == ADDR_MAX_LEN)    ? {8'h00, max_len_r} :
		(addr == ADDR_PPI)        ? {16'h0000, ppi_r} :
		(addr == ADDR_STATUS)     ? status_w :
		(addr == ADDR_HEIGHT)     ? {16'h0000, height_r} :
		(addr == ADDR_LC_GLITCH)  ? 32'(cnt_lc_glt) :
		(addr == ADDR_TIMEOUT)    ? 32'(cnt_timeout) :
		(addr == ADDR_PE_GLITCH)  ? 32'(cnt_pe_glt) :
		(addr == ADDR_TACH_TOTAL) ? tach_total_r :
		(addr == ADDR_SPEED)      ? {16'h0000, speed_r} :
		(addr == ADDR_SPEED_MIN)  ? {16'h0000, speed_min_r} :
		(addr == ADDR_SPEED_MAX)  ? {16'h0000, speed_max_r} :
		(addr == ADDR_DEVIATION)  ? {16'h0000, dev_r} :
		(addr == ADDR_TOO_LONG)   ? 32'(cnt_long) :
		(addr == ADDR_TOO_SHORT)  ? 32'(cnt_short) :
		(addr == ADDR_TOO_CLOSE)  ? 32'(cnt_close) : 32'h0000_0000;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			rdata_r <= 32'h0000_0000;
		else
			rdata_r <= rd_en ? rd_mux : 32'h0000_0000;
	end

	assign rdata       = rdata_r;
	assign pkg_present = pkg_present_r;

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	chk_mode_select: assert property (
		##1 pkg_present_r == (($past(mode_r)) ? $past(lc_present_r)
		                                      : $past(pe_present_r)))
		else $error("present does not follow selected mode");
	chk_char_hold: assert property (
		lc_char_valid && lc_on |=> char_r == $past(lc_char))
		else $error("raw character not held");
	chk_height_calc: assert property (
		lc_take |=> height_r == 16'($past(lc_char)) * 16'($past(res_r))
		                        + $past(off_r))
		else $error("height conversion wrong");
	chk_lc_min_time: assert property (
		$rose(lc_present_r) |-> $past(lc_run_r) >= $past(min_time_r))
		else $error("curtain present before minimum time");
	chk_lc_idle_mode: assert property (
		pe_on |-> ##1 !lc_timeout_r && !lc_glitch_r && !lc_present_r)
		else $error("curtain monitor active in photoeye mode");
	chk_timeout_gap: assert property (
		lc_timeout_r |-> $past(idle_r) == 32'(TIMEOUT_CYC - 1))
		else $error("timeout without full idle period");
	chk_pe_raw: assert property (
		##1 pe_raw_r == $past(pe_in))
		else $error("raw photoeye level wrong");
	chk_pe_polarity: assert property (
		$rose(pe_present_r) |-> $past(pe_in ^ act_low_r)
		                        && $past(pe_run_r) >= $past(min_time_r))
		else $error("photoeye present with wrong polarity or time");
	chk_tach_wrap: assert property (
		tach_edge |=> tach_total_r == $past(tach_total_r) + 32'h0000_0001)
		else $error("tach total not stepped");
	chk_min_max: assert property (
		sec_tick && !fresh_r |=> speed_min_r <= speed_r
		                         && speed_max_r >= speed_r)
		else $error("speed min or max not tracking");
	chk_dev_update: assert property (
		win_end |=> dev_r == 16'($past(sum_nxt) / 24'(WINDOW_S))
		            && dev_sum_r == 24'h00_0000)
		else $error("deviation not updated at window end");
	chk_reset_counts: assert property (
		rst_cnt_r |=> cnt_long <= CNT_W'(1) && cnt_close <= CNT_W'(1))
		else $error("counts not cleared");

	cov_lc_glitch: cover property (lc_glitch_r);
	cov_timeout:   cover property (lc_timeout_r);
	cov_pe_glitch: cover property (pe_glitch_r);
	cov_too_close: cover property (too_close_r);
endmodule
`default_nettype wire

/* File: tb/sensor_model.sv */
// Light curtain, photoeye and tachometer stand-in for the bench
`default_nettype none
module sensor_model (
	input  wire logic       core_clk,      // System clock
	input  wire logic [3:0] tach_half,     // Tach half period, 0 stops
	output logic            lc_char_valid, // Curtain character strobe
	output logic [7:0]      lc_char,       // Curtain character
	output logic            pe_in,         // Photoeye level
	output logic            tach_in        // Tach pulse line
);
	timeunit 1ns;
	timeprecision 1ps;
	int tach_cnt;
	int pulses;
	initial
	begin
		lc_char_valid = 1'b0;
		lc_char = 8'h00;
		pe_in = 1'b0;
		tach_in = 1'b0;
		tach_cnt = 0;
		pulses = 0;
	end
	// Tach toggles freely, parks low when stopped
	always @(posedge core_clk)
	begin
		if (tach_half == 4'h0)
			tach_in <= 1'b0;
		else if (tach_cnt + 1 >= tach_half)
		begin
			tach_cnt <= 0;
			tach_in <= ~tach_in;
			if (!tach_in)
				pulses <= pulses + 1;
		end
		else
			tach_cnt <= tach_cnt + 1;
	end
	// One-cycle strobe; data line scrambled afterwards
	task automatic send_char(input logic [7:0] c);
		@(posedge core_clk);
		lc_char_valid <= 1'b1;
		lc_char <= c;
		@(posedge core_clk);
		lc_char_valid <= 1'b0;
		lc_char <= ~c;
	endtask
	task automatic set_pe(input logic l);
		@(posedge core_clk);
		pe_in <= l;
	endtask
endmodule
`default_nettype wire

/* File: tb/package_trigger_monitor_tb_top.sv */
// Self-checking bench for the package trigger monitor
`default_nettype none
module package_trigger_monitor_tb_top
	import trig_mon_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 20000;
	logic        core_clk;
	logic        rstn;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr_en;
	logic        rd_en;
	logic [31:0] rdata;
	logic        lc_char_valid;
	logic [7:0]  lc_char;
	logic        pe_in;
	logic        tach_in;
	logic        pkg_present;
	logic [3:0]  tach_half;
	logic [31:0] d;
	logic [31:0] seed;
	int          num_errors;
	int          n_checks;
	int          cyc;
	int          res, off, h;
	int          e_long, e_short, e_close, e_glt;
	int          hq[$];
	int          dur[3] = '{300, 40, 100};
	int          gap[3] = '{100, 20, 100};
	logic [7:0]  chs[5] = '{8'h05, 8'h1D, 8'h05, 8'h07, 8'h08};

	package_trigger_monitor #(.TIMEOUT_CYC(50), .SPEED_CYC(20)) dut (
		.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.lc_char_valid(lc_char_valid), .lc_char(lc_char), .pe_in(pe_in),
		.tach_in(tach_in), .pkg_present(pkg_present)
	);
	sensor_model m (
		.core_clk(core_clk), .tach_half(tach_half),
		.lc_char_valid(lc_char_valid), .lc_char(lc_char), .pe_in(pe_in),
		.tach_in(tach_in)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		chk_reg({31'h0, got}, {31'h0, exp});
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		reg_rd(a);
		chk_reg(d, e);
	endtask
	task automatic results;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Watchdog on total run length
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			num_errors++;
			results();
		end
	end

	initial
	begin
		rstn = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		tach_half = 4'h0;
		seed = 32'h0000_0044;
		num_errors = 0;
		n_checks = 0;
		cyc = 0;
		e_glt = 0;
		wait_cyc(3);
		rstn <= 1'b1;
		rd_chk(ADDR_CTRL, 32'h0000_0000);
		rd_chk(ADDR_LC_CFG, 32'h0000_0001);
		rd_chk(ADDR_TACH_TOTAL, 32'h0000_0000);
		rd_chk(8'hFC, 32'h0000_0000);
		reg_wr(ADDR_MIN_TIME, 32'h0000_0004);
		reg_wr(ADDR_DEBOUNCE, 32'h0000_0006);
		reg_wr(ADDR_PPI, 32'h0000_0008);
		reg_wr(ADDR_MAX_LEN, 32'h0000_0064);
		rd_chk(ADDR_MAX_LEN, 32'h0000_0064);
		// Photoeye mode: curtain ignored, short blip is a glitch
		m.send_char(8'h41);
		reg_rd(ADDR_STATUS);
		chk_reg({24'h0, d[15:8]}, 32'h0000_0000);
		m.set_pe(1'b1);
		wait_cyc(1);
		m.set_pe(1'b0);
		wait_cyc(12);
		rd_chk(ADDR_PE_GLITCH, 32'h0000_0001);
		chk_pin(pkg_present, 1'b0);
		// Active-low with input low
		reg_wr(ADDR_CTRL, 32'h0000_0002);
		wait_cyc(20);
		chk_pin(pkg_present, 1'b1);
		reg_rd(ADDR_STATUS);
		chk_reg({28'h0, d[3:0]}, 32'h0000_0009);
		m.set_pe(1'b1);
		wait_cyc(20);
		chk_pin(pkg_present, 1'b0);
		rd_chk(ADDR_TOO_SHORT, 32'h0000_0001);
		reg_wr(ADDR_CTRL, 32'h0000_0102);
		rd_chk(ADDR_TOO_SHORT, 32'h0000_0000);
		rd_chk(ADDR_PE_GLITCH, 32'h0000_0000);
		rd_chk(ADDR_CTRL, 32'h0000_0002);
		// Package run with tach at two cycles per pulse
		e_long = 0;
		e_short = 0;
		e_close = 0;
		tach_half <= 4'h1;
		foreach (dur[i])
		begin
			wait_cyc(gap[i]);
			m.set_pe(1'b0);
			wait_cyc(dur[i]);
			m.set_pe(1'b1);
			e_long += (dur[i] / 2 > 100);
			e_short += (dur[i] / 2 * 10 < 40 * 8);
			e_close += (gap[i] / 2 * 10 < 20 * 8);
		end
		wait_cyc(100);
		tach_half <= 4'h0;
		wait_cyc(5);
		rd_chk(ADDR_TOO_LONG, e_long);
		rd_chk(ADDR_TOO_SHORT, e_short);
		rd_chk(ADDR_TOO_CLOSE, e_close);
		rd_chk(ADDR_TACH_TOTAL, m.pulses);
		// Slow then fast belt inside one tracking block
		tach_half <= 4'h2;
		wait_cyc(40);
		while ((cyc - 3) % 600 != 50)
			wait_cyc(1);
		reg_wr(ADDR_CTRL, 32'h0000_0102);
		wait_cyc(150);
		tach_half <= 4'h1;
		wait_cyc(150);
		rd_chk(ADDR_SPEED, 32'h0000_000A);
		rd_chk(ADDR_SPEED_MIN, 32'h0000_0005);
		rd_chk(ADDR_SPEED_MAX, 32'h0000_000A);
		// Curtain mode with random resolution and offset
		seed = xs(seed);
		res = int'(seed % 7) + 1;
		seed = xs(seed);
		off = int'(seed % 32768);
		reg_wr(ADDR_LC_CFG, {off[15:0], 8'h00, res[7:0]});
		reg_wr(ADDR_CTRL, 32'h0000_0003);
		foreach (chs[i])
		begin
			m.send_char(chs[i]);
			h = int'(chs[i]) * res + off;
			hq.push_back(h);
			if (hq.size() > 3)
				void'(hq.pop_front());
			if (hq.size() == 3 && (hq[1] - hq[0] > 16 || hq[0] - hq[1] > 16)
				&& (hq[1] - hq[2] > 16 || hq[2] - hq[1] > 16))
				e_glt++;
			reg_rd(ADDR_STATUS);
			chk_reg({24'h0, d[15:8]}, chs[i]);
			rd_chk(ADDR_HEIGHT, h);
		end
		rd_chk(ADDR_LC_GLITCH, e_glt);
		chk_pin(pkg_present, 1'b1);
		m.set_pe(1'b0);
		wait_cyc(2);
		m.set_pe(1'b1);
		wait_cyc(10);
		rd_chk(ADDR_PE_GLITCH, 32'h0000_0000);
		reg_wr(ADDR_LC_CFG, {24'h0, res[7:0]});
		m.send_char(8'h00);
		wait_cyc(70);
		chk_pin(pkg_present, 1'b0);
		rd_chk(ADDR_TIMEOUT, 32'h0000_0001);
		results();
	end
endmodule
`default_nettype wire
